// File: include/qdsl_params.svh
`ifndef QDSL_PARAMS_SVH
`define QDSL_PARAMS_SVH

// word layout, msb first on the link
`define QDSL_WORD_BITS 16
`define QDSL_SEL_HI 15
`define QDSL_SEL_LO 14
`define QDSL_MODE_HI 13
`define QDSL_MODE_LO 12
`define QDSL_CODE_HI 11
`define QDSL_CODE_LO 2
`define QDSL_TERM_HI 11
`define QDSL_TERM_LO 10

// register byte offsets
`define QDSL_OFS_CODE_AB 8'h00
`define QDSL_OFS_CODE_CD 8'h04
`define QDSL_OFS_STATUS 8'h08
`define QDSL_OFS_CONTROL 8'h0c

// reset values
`define QDSL_CODE_RST 10'h000
`define QDSL_CONTROL_RST 1'b1

`endif

// File: include/qdsl_pkg.sv
package qdsl_pkg;

    typedef enum logic [1:0] {
        QDSL_MODE_WRITE = 2'b00,
        QDSL_MODE_UPD_ONE = 2'b01,
        QDSL_MODE_UPD_ALL = 2'b10,
        QDSL_MODE_PWR_DOWN = 2'b11
    } qdsl_mode_t;

    typedef enum logic [1:0] {
        QDSL_TERM_ACTIVE = 2'b00,
        QDSL_TERM_1K = 2'b01,
        QDSL_TERM_100K = 2'b10,
        QDSL_TERM_HIZ = 2'b11
    } qdsl_term_t;

endpackage : qdsl_pkg

// File: rtl/qdsl_top.sv
// Behaviour
// R1 - after sync falls, data bits shift in on each falling serial clock edge
// R2 - shifting happens only while sync is held low; the code also shifts on falling edges with sync_n high
// R3 - the sixteenth falling edge of a frame delivers the word for action
// R4 - sync rising before sixteen edges aborts and drops the partial word
// R5 - all outputs read zero code until the first complete valid write
// R6 - word carries output select, mode, power-down setting and code
// R7 - mode field picks single output update or all four together
// R8 - power-down state with three selectable output terminations
// R9 - four separate 10-bit codes, channels a through d
// R10 - host keeps serial clock at or below 40 MHz
// R11 - word travels most significant bit first

`include "qdsl_params.svh"

module qdsl_top
    import qdsl_pkg::*;
(
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // serial link
    input wire logic link_sclk,
    input wire logic sync_n,
    input wire logic din,
    // converter outputs
    output logic [9:0] analog_out_a,
    output logic [9:0] analog_out_b,
    output logic [9:0] analog_out_c,
    output logic [9:0] analog_out_d,
    output logic [1:0] pd_term
);

    // ------------------------------------------------------------
    // link domain: shift and bit count
    // ------------------------------------------------------------
    // sync_n high clears the count asynchronously: the serial clock
    // may stop right after an aborted frame, so no edge can be relied on
    logic [4:0] bit_cnt_reg;
    logic [4:0] bit_cnt_next;
    logic [15:0] shift_reg;
    logic [15:0] shift_next;
    logic [15:0] word_reg;
    logic [15:0] word_next;
    logic word_tog_reg;
    logic word_tog_next;
    logic last_bit;

    always_comb begin
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        word_next = word_reg;
        word_tog_next = word_tog_reg;
        last_bit = (bit_cnt_reg == 5'h0f);
        if (bit_cnt_reg < 5'h10) begin // caps the frame at sixteen bits; shifting is not gated by sync_n (R2)
            shift_next = {shift_reg[14:0], din}; // R1 R11
            bit_cnt_next = bit_cnt_reg + 5'h01;
        end
        if (last_bit) begin // R3
            word_next = {shift_reg[14:0], din};
            word_tog_next = ~word_tog_reg;
        end
    end

    always_ff @(negedge link_sclk or posedge sync_n) begin
        if (sync_n) begin
            bit_cnt_reg <= 5'h00; // R4
        end else begin
            bit_cnt_reg <= bit_cnt_next; // R1
        end
    end

    always_ff @(negedge link_sclk) begin
        shift_reg <= shift_next;
    end

    // word and toggle only change on the sixteenth edge
    always_ff @(negedge link_sclk or negedge rst_n) begin
        if (!rst_n) begin
            word_reg <= 16'h0000;
            word_tog_reg <= 1'b0;
        end else begin
            word_reg <= word_next;
            word_tog_reg <= word_tog_next;
        end
    end

    // ------------------------------------------------------------
    // crossing into core domain
    // ------------------------------------------------------------
    // word_reg is stable for at least sixteen serial clocks after the
    // toggle moves, far longer than the three-stage crossing takes
    logic tog_s1_reg;
    logic tog_s2_reg;
    logic tog_s3_reg;
    logic tog_seen_reg;
    logic tog_seen_next;
    logic word_evt;

    always_comb begin
        word_evt = (tog_s2_reg == tog_s3_reg) && (tog_s3_reg != tog_seen_reg);
        tog_seen_next = word_evt ? tog_s3_reg : tog_seen_reg;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            tog_s3_reg <= 1'b0;
            tog_seen_reg <= 1'b0;
        end else begin
            tog_s1_reg <= word_tog_reg;
            tog_s2_reg <= tog_s1_reg;
            tog_s3_reg <= tog_s2_reg;
            tog_seen_reg <= tog_seen_next;
        end
    end

    // ------------------------------------------------------------
    // word decode and channel update
    // ------------------------------------------------------------
    logic [1:0] w_sel;
    qdsl_mode_t w_mode;
    logic [9:0] w_code;
    logic [1:0] w_term;
    logic accept_reg;
    logic accept_next;

    logic [9:0] hold_reg [4];
    logic [9:0] hold_next [4];
    logic [9:0] out_reg [4];
    logic [9:0] out_next [4];
    logic [1:0] pd_reg;
    logic [1:0] pd_next;
    logic written_reg;
    logic written_next;
    logic [7:0] frames_reg;
    logic [7:0] frames_next;
    logic [7:0] dropped_reg;
    logic [7:0] dropped_next;
    logic valid_word;

    always_comb begin
        w_sel = word_reg[`QDSL_SEL_HI:`QDSL_SEL_LO]; // R6
        w_mode = qdsl_mode_t'(word_reg[`QDSL_MODE_HI:`QDSL_MODE_LO]);
        w_code = word_reg[`QDSL_CODE_HI:`QDSL_CODE_LO];
        w_term = word_reg[`QDSL_TERM_HI:`QDSL_TERM_LO];
        // power-down with no termination chosen is not a valid word
        valid_word = accept_reg &&
            !((w_mode == QDSL_MODE_PWR_DOWN) && (w_term == 2'b00));
        for (int i = 0; i < 4; i++) begin
            hold_next[i] = hold_reg[i];
            out_next[i] = out_reg[i];
        end
        pd_next = pd_reg;
        written_next = written_reg;
        frames_next = frames_reg;
        dropped_next = dropped_reg;
        if (word_evt && !valid_word) begin
            dropped_next = dropped_reg + 8'h01;
        end
        if (word_evt && valid_word) begin
            frames_next = frames_reg + 8'h01;
            written_next = 1'b1; // R5
            case (w_mode) // R7
                QDSL_MODE_WRITE: begin
                    hold_next[w_sel] = w_code;
                end
                QDSL_MODE_UPD_ONE: begin
                    hold_next[w_sel] = w_code; // R9
                    out_next[w_sel] = w_code;
                    pd_next = QDSL_TERM_ACTIVE;
                end
                QDSL_MODE_UPD_ALL: begin
                    for (int i = 0; i < 4; i++) begin
                        out_next[i] = (w_sel == 2'(i)) ? w_code
                                                       : hold_reg[i];
                    end
                    hold_next[w_sel] = w_code;
                    pd_next = QDSL_TERM_ACTIVE;
                end
                QDSL_MODE_PWR_DOWN: begin
                    pd_next = w_term; // R8
                end
                default: begin
                    pd_next = pd_reg;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                hold_reg[i] <= `QDSL_CODE_RST;
                out_reg[i] <= `QDSL_CODE_RST; // R5
            end
            pd_reg <= 2'b00;
            written_reg <= 1'b0;
            frames_reg <= 8'h00;
            dropped_reg <= 8'h00;
        end else begin
            for (int i = 0; i < 4; i++) begin
                hold_reg[i] <= hold_next[i];
                out_reg[i] <= out_next[i];
            end
            pd_reg <= pd_next;
            written_reg <= written_next;
            frames_reg <= frames_next;
            dropped_reg <= dropped_next;
        end
    end

    assign analog_out_a = out_reg[0];
    assign analog_out_b = out_reg[1];
    assign analog_out_c = out_reg[2];
    assign analog_out_d = out_reg[3];
    assign pd_term = pd_reg;

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;
    logic wb_req;

    always_comb begin
        wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
        ack_next = wb_req;
        rdat_next = rdat_reg;
        accept_next = accept_reg;
        if (wb_req && wb_we_i) begin
            if ((wb_adr_i == `QDSL_OFS_CONTROL) && wb_sel_i[0]) begin
                accept_next = wb_dat_i[0];
            end
        end
        if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                `QDSL_OFS_CODE_AB: rdat_next = {6'h00, out_reg[1],
                                                6'h00, out_reg[0]};
                `QDSL_OFS_CODE_CD: rdat_next = {6'h00, out_reg[3],
                                                6'h00, out_reg[2]};
                `QDSL_OFS_STATUS: rdat_next = {8'h00, dropped_reg,
                                               frames_reg, 5'h00,
                                               pd_reg, written_reg};
                `QDSL_OFS_CONTROL: rdat_next = {31'h0, accept_reg};
                default: rdat_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
            accept_reg <= `QDSL_CONTROL_RST;
        end else begin
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            accept_reg <= accept_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

endmodule : qdsl_top

// File: verification/qdsl_host_model.sv
module qdsl_host_model (
    // serial link toward the device
    output logic link_sclk,
    output logic sync_n,
    output logic din
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        link_sclk = 1'b1;
        sync_n = 1'b1;
        din = 1'b0;
    end
    // clock stands still high between frames, 30 ns period
    task automatic send(input logic [15:0] w, input int n);
        sync_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            din = w[15 - (i % 16)];
            #15 link_sclk = 1'b0;
            #15 link_sclk = 1'b1;
        end
        #5 sync_n = 1'b1;
        din = ~din;
        #100;
    endtask : send
endmodule : qdsl_host_model

// File: verification/qdsl_assertions.sv
module qdsl_assertions (
    // core
    input wire logic core_clk,
    input wire logic rst_n,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // link and outputs
    input wire logic link_sclk,
    input wire logic sync_n,
    input wire logic [9:0] analog_out_a,
    input wire logic [9:0] analog_out_b,
    input wire logic [9:0] analog_out_c,
    input wire logic [9:0] analog_out_d,
    input wire logic [1:0] pd_term
);
    logic [41:0] outs;
    logic [3:0] gap_reg, gap_next;
    logic sck_reg;
    assign outs = {analog_out_a, analog_out_b, analog_out_c,
        analog_out_d, pd_term};
    // core cycles since the last serial falling edge, saturating
    always_comb begin
        gap_next = gap_reg + {3'h0, gap_reg != 4'hf};
        if (sck_reg && !link_sclk) begin
            gap_next = 4'h0;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_reg <= 4'hf;
            sck_reg <= 1'b1;
        end else begin
            gap_reg <= gap_next;
            sck_reg <= link_sclk;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("no ack");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
        else $error("stray ack");
    dat_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data moved");
    zero_start_a: assert property ($rose(rst_n) |-> outs == 42'h0)
        else $error("outputs not zero");
    edge_cause_a: assert property ($changed(outs) |-> gap_reg < 4'h9)
        else $error("update without frame");
    idle_hold_a: assert property (sync_n [*8] |=> $stable(outs))
        else $error("update while idle");
    pd_code_a: assert property ($changed(pd_term) && pd_term != 2'h0
        |-> $stable(outs[41:2])) else $error("codes moved");
endmodule : qdsl_assertions

bind qdsl_top qdsl_assertions chk (.core_clk, .rst_n, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .wb_dat_o, .link_sclk, .sync_n, .analog_out_a,
    .analog_out_b, .analog_out_c, .analog_out_d, .pd_term);

// File: verification/quad_dac_serial_load_tb_top.sv
`include "qdsl_params.svh"

module quad_dac_serial_load_tb_top
    import qdsl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, link_sclk, sync_n, din, acc_e;
    logic [9:0] analog_out_a, analog_out_b, analog_out_c, analog_out_d;
    logic [9:0] hold_e [4];
    logic [9:0] out_e [4];
    logic [1:0] pd_term, pd_e;
    int fails = 0;
    int total_checks = 0;
    int nval = 0;
    int ndrop = 0;
    always #5 core_clk = ~core_clk;
    qdsl_top dut (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .link_sclk,
        .sync_n, .din, .analog_out_a, .analog_out_b, .analog_out_c,
        .analog_out_d, .pd_term);
    qdsl_host_model host (.link_sclk, .sync_n, .din);

    task automatic complete_run();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [41:0] got, input logic [41:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic wb(input logic we, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            fails++;
            complete_run();
        end
    endtask : wb

    function automatic void apply(input logic [15:0] w);
        int c;
        c = w[15:14];
        if (w[13:12] != QDSL_MODE_PWR_DOWN) hold_e[c] = w[11:2];
        if (w[13:12] == QDSL_MODE_UPD_ONE) out_e[c] = w[11:2];
        if (w[13:12] == QDSL_MODE_UPD_ALL) out_e = hold_e;
        if (w[13:12] == QDSL_MODE_PWR_DOWN) pd_e = w[11:10];
        else if (w[13:12] != QDSL_MODE_WRITE) pd_e = 2'h0;
    endfunction : apply

    task automatic frame(input logic [15:0] w, input int n);
        host.send(w, n);
        // power-down with no termination chosen is refused by the device
        if (n >= 16 && acc_e && !(w[13:12] == QDSL_MODE_PWR_DOWN &&
                w[11:10] == 2'h0)) begin
            apply(w);
            nval++;
        end else if (n >= 16) ndrop++;
        check({analog_out_a, analog_out_b, analog_out_c, analog_out_d,
            pd_term}, {out_e[0], out_e[1], out_e[2], out_e[3], pd_e});
    endtask : frame

    initial begin
        logic [15:0] w;
        rd = $urandom(40267);
        out_e = '{default: 10'h0};
        hold_e = '{default: 10'h0};
        pd_e = 2'h0;
        acc_e = 1'b1;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        wb(1'b0, `QDSL_OFS_CONTROL, 32'h0);
        check({10'h0, rd}, 42'h1);
        frame({2'h1, QDSL_MODE_WRITE, 10'h2a5, 2'h0}, 16);
        wb(1'b0, `QDSL_OFS_STATUS, 32'h0);
        check({41'h0, rd[0]}, 42'h1);
        frame(16'h6ffc, 10);
        frame(16'h1ffc, 18);
        for (int i = 0; i < 24; i++) begin
            w = 16'($urandom);
            if (w[13:12] == 2'b11) w[13:12] = QDSL_MODE_UPD_ALL;
            frame(w, 16);
        end
        for (int t = 1; t < 4; t++) begin
            frame({2'h2, QDSL_MODE_PWR_DOWN, 2'(t), 8'h0, 2'h0}, 16);
            frame({2'h3, QDSL_MODE_UPD_ONE, 10'h155, 2'h0}, 16);
        end
        frame({2'h1, QDSL_MODE_PWR_DOWN, 10'h0, 2'h0}, 16);
        wb(1'b1, `QDSL_OFS_CONTROL, 32'h0);
        acc_e = 1'b0;
        frame(16'h5004, 16);
        wb(1'b1, `QDSL_OFS_CONTROL, 32'h1);
        acc_e = 1'b1;
        wb(1'b0, `QDSL_OFS_STATUS, 32'h0);
        check({10'h0, rd & 32'hffff07}, {18'h0, 8'(ndrop), 8'(nval),
            5'h0, pd_e, 1'b1});
        frame({2'h0, QDSL_MODE_UPD_ALL, 10'h0cc, 2'h0}, 16);
        wb(1'b0, `QDSL_OFS_CODE_AB, 32'h0);
        check({10'h0, rd & 32'h3ff03ff}, {16'h0, out_e[1], 6'h0,
            out_e[0]});
        wb(1'b1, 8'h40, 32'hffffffff);
        wb(1'b0, 8'h40, 32'h0);
        check({10'h0, rd}, 42'h0);
        complete_run();
    end
endmodule : quad_dac_serial_load_tb_top
